// ==== bench/lscs_fw_model.sv ====
// lscs_fw_model: firmware side of the register port, byte accesses and the
// crystal start-up sequence.
// assumes one clock domain and read data standing one cycle after the strobe.
`timescale 1ns/10ps
module lscs_fw_model
   import lscs_pkg::*;
(
   input  wire logic                   sys_clk_in,
   input  wire logic [LSCS_DATA_W-1:0] rdata_in,
   output logic [LSCS_ADDR_W-1:0]      addr_out,
   output logic [LSCS_DATA_W-1:0]      wdata_out,
   output logic                        wr_out,
   output logic                        rd_out,
   output logic                        sleep_clear_out
);
   // idle bus from time zero
   initial begin
      addr_out        = 9'h000;
      wdata_out       = 8'h00;
      wr_out          = 1'b0;
      rd_out          = 1'b0;
      sleep_clear_out = 1'b0;
   end

   // one-cycle write strobe; address and data held through the sampling edge
   task automatic wr_reg(input logic [8:0] a, input logic [7:0] d);
      @(posedge sys_clk_in);
      addr_out  <= a;
      wdata_out <= d;
      wr_out    <= 1'b1;
      @(posedge sys_clk_in);
      wr_out    <= 1'b0;
   endtask

   // data stands only in the cycle after the strobe, so it is taken there
   task automatic rd_reg(input logic [8:0] a, output logic [7:0] d);
      @(posedge sys_clk_in);
      addr_out <= a;
      rd_out   <= 1'b1;
      @(posedge sys_clk_in);
      rd_out   <= 1'b0;
      #1;
      d = rdata_in;
   endtask

   // restarting the timer guarantees the full settling interval
   task automatic clear_sleep();
      @(posedge sys_clk_in);
      sleep_clear_out <= 1'b1;
      @(posedge sys_clk_in);
      sleep_clear_out <= 1'b0;
   endtask

   // interval first, then select with reserved bits zero, then timer restart
   task automatic enable_crystal(input logic [1:0] iv);
      wr_reg(LSCS_OSC_CTRL0_ADDR, {3'h0, iv, 3'h0});
      wr_reg(LSCS_OSC_CTRL0_ADDR, {3'h4, iv, 3'h0});
      clear_sleep();
   endtask
endmodule

// ==== bench/tb_top.sv ====
// tb_top: directed bench of the low-speed clock source switch.
// assumes the firmware model owns the register port; tick divider set to 2.
`timescale 1ns/10ps
module tb_top;
   import lscs_pkg::*;
   logic        sys_clk_in, rst_n_in, boot_rep, ext_en, wr, rd, sclr;
   logic        xtal, internal_low_speed_osc, pend, tmo, rim, slow, early, seen;
   logic [8:0]  addr;
   logic [7:0]  wdata, rdata, rv;
   logic [15:0] khz;
   int          n_fail, tests_run;

   lscs_top #(.TICK_DIV(2)) dut (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .addr_in(addr),
      .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .sleep_clear_in(sclr), .boot_repeat_in(boot_rep),
      .ext_clk_en_in(ext_en), .rdata_out(rdata), .xtal_src_out(xtal), .ilo_en_out(internal_low_speed_osc),
      .src_pending_out(pend), .sleep_timeout_out(tmo), .ram_init_max_out(rim),
      .main_osc_khz_out(khz), .system_clock_net_slow_out(slow));
   lscs_fw_model fw (.sys_clk_in(sys_clk_in), .rdata_in(rdata), .addr_out(addr), .wdata_out(wdata),
      .wr_out(wr), .rd_out(rd), .sleep_clear_out(sclr));

   // 100 MHz clock
   initial begin
      sys_clk_in = 1'b0;
      forever #5 sys_clk_in = ~sys_clk_in;
   end

   task automatic check(input string name, input logic [15:0] seen_v, input logic [15:0] exp);
      tests_run++;
      if (seen_v !== exp) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", name, exp, seen_v);
      end
   endtask

   task automatic rd_chk(input string name, input logic [8:0] a, input logic [7:0] exp);
      fw.rd_reg(a, rv);
      check(name, {8'h00, rv}, {8'h00, exp});
   endtask

   task automatic close_out();
      $display("counts: %0d compared, %0d mismatched", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task automatic settle(input int n);
      repeat (n) @(posedge sys_clk_in);
      #1;
   endtask

   // waits for the timer pulse; notes any source change seen before it
   task automatic wait_switch(input int limit);
      early = 1'b0;
      seen  = 1'b0;
      for (int i = 0; i < limit && !seen; i++) begin
         settle(1);
         if (tmo === 1'b1)
            seen = 1'b1;
         else if (xtal !== 1'b0 || internal_low_speed_osc !== 1'b1)
            early = 1'b1;
      end
      settle(1);
   endtask

   task automatic do_reset();
      @(posedge sys_clk_in);
      rst_n_in <= 1'b0;
      settle(2);
      check("xtal in reset", {15'h0, xtal}, 16'h0000);
      check("ilo in reset", {15'h0, internal_low_speed_osc}, 16'h0001);
      check("ram init in reset", {15'h0, rim}, 16'h0001);
      check("khz in reset", khz, LSCS_MAIN_KHZ_FAST);
      @(posedge sys_clk_in);
      rst_n_in <= 1'b1;
   endtask

   // a flag written as zero locks the crystal out for good
   task automatic t_lockout();
      rd_chk("osc ctrl reset", LSCS_OSC_CTRL0_ADDR, 8'h00);
      rd_chk("sys bank0 reset", 9'h0FE, 8'h00);
      fw.wr_reg(9'h0FE, 8'h00);
      rd_chk("written set", 9'h0FE, 8'h08);
      fw.wr_reg(9'h0FE, 8'h04);
      rd_chk("flag locked", 9'h0FE, 8'h08);
      fw.wr_reg(LSCS_OSC_CTRL0_ADDR, 8'h80);
      wait_switch(400);
      check("timeout seen", {15'h0, seen}, 16'h0001);
      check("locked xtal", {15'h0, xtal}, 16'h0000);
      check("locked pend", {15'h0, pend}, 16'h0000);
      $display("test lockout done");
   endtask

   // slow, ram-init and flag bits through the bank 1 alias
   task automatic t_flags();
      fw.wr_reg(9'h1FE, 8'h15);
      rd_chk("sys bank1 write", 9'h0FE, 8'h1D);
      check("ram init min", {15'h0, rim}, 16'h0000);
      check("slow khz", khz, LSCS_MAIN_KHZ_SLOW);
      check("system_clock_net slow", {15'h0, slow}, 16'h0001);
      @(posedge sys_clk_in);
      ext_en <= 1'b1;
      settle(3);
      check("ext clock slow", {15'h0, slow}, 16'h0000);
      @(posedge sys_clk_in);
      ext_en <= 1'b0;
      fw.wr_reg(9'h0FE, 8'h00);
      rd_chk("flag kept", 9'h1FE, 8'h0C);
      check("ram init max", {15'h0, rim}, 16'h0001);
      check("fast khz", khz, LSCS_MAIN_KHZ_FAST);
      @(posedge sys_clk_in);
      boot_rep <= 1'b1;
      settle(6);
      rd_chk("boot repeat set", 9'h0FE, 8'h8C);
      @(posedge sys_clk_in);
      boot_rep <= 1'b0;
      settle(6);
      rd_chk("boot repeat clear", 9'h0FE, 8'h0C);
      $display("test flags done");
   endtask

   // deferred switch on the one-second edge, pll rate, then immediate return
   task automatic t_switch();
      fw.enable_crystal(LSCS_SLEEP_1S);
      settle(2);
      check("pending", {15'h0, pend}, 16'h0001);
      rd_chk("status pending", LSCS_SRC_STAT_ADDR, 8'h06);
      wait_switch(70000);
      check("held on ilo", {15'h0, early}, 16'h0000);
      check("one second edge", {15'h0, seen}, 16'h0001);
      check("xtal source", {15'h0, xtal}, 16'h0001);
      check("ilo stopped", {15'h0, internal_low_speed_osc}, 16'h0000);
      fw.wr_reg(LSCS_OSC_CTRL0_ADDR, 8'hD8);
      settle(3);
      check("pll khz", khz, LSCS_MAIN_KHZ_PLL);
      fw.wr_reg(LSCS_OSC_CTRL0_ADDR, 8'h18);
      settle(3);
      check("back to ilo", {15'h0, xtal}, 16'h0000);
      check("ilo restarted", {15'h0, internal_low_speed_osc}, 16'h0001);
      check("khz after return", khz, LSCS_MAIN_KHZ_FAST);
      fw.wr_reg(LSCS_OSC_CTRL0_ADDR, 8'h80);
      fw.clear_sleep();
      wait_switch(400);
      check("free reswitch", {15'h0, xtal}, 16'h0001);
      $display("test switch done");
   endtask

   // cuts a hung run short; whole run is about 70k cycles
   initial begin
      #900_000;
      n_fail++;
      close_out();
   end

   // main sequence
   initial begin
      n_fail   = 0;
      tests_run = 0;
      rst_n_in = 1'b0;
      boot_rep = 1'b0;
      ext_en   = 1'b0;
      repeat (2) @(posedge sys_clk_in);
      rst_n_in <= 1'b1;
      t_lockout();
      do_reset();
      t_flags();
      t_switch();
      close_out();
   end
endmodule

// ==== logic/lscs_sleep_timer.sv ====
// lscs_sleep_timer: sleep timer on 32 kHz ticks, pulses at interval end.
// assumes tick_in is a one-cycle enable and clear_in a one-cycle pulse.
`timescale 1ns/10ps
module lscs_sleep_timer
   import lscs_pkg::*;
(
   input  wire logic        sys_clk_in,
   input  wire logic        rst_n_in,
   input  wire logic        tick_in,
   input  wire logic        clear_in,
   input  wire logic [1:0]  interval_in,
   output logic             timeout_out
);
   logic [LSCS_SLEEP_CNT_W-1:0] cnt_q;
   logic [LSCS_SLEEP_CNT_W-1:0] limit;

   // terminal count per interval code
   always_comb begin
      unique case (interval_in)
         2'h0: limit = LSCS_SLEEP_TICKS0;
         2'h1: limit = LSCS_SLEEP_TICKS1;
         2'h2: limit = LSCS_SLEEP_TICKS2;
         2'h3: limit = LSCS_SLEEP_TICKS3;
      endcase
   end

   // counter restarts on clear or at terminal count
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cnt_q       <= '0;
         timeout_out <= 1'b0;
      end else begin
         timeout_out <= 1'b0;
         if (clear_in) begin
            cnt_q <= '0;
         end else if (tick_in) begin
            if (cnt_q >= limit) begin
               cnt_q       <= '0;
               timeout_out <= 1'b1;
            end else begin
               cnt_q <= cnt_q + 1'b1;
            end
         end
      end
   end
endmodule

// ==== logic/lscs_sync.sv ====
// lscs_sync: two-flop synchroniser for a level from outside the clock domain.
// assumes the level stays stable for more than two clock periods.
`timescale 1ns/10ps
module lscs_sync (
   input  wire logic sys_clk_in,
   input  wire logic rst_n_in,
   input  wire logic async_in,
   output logic      sync_out
);
   logic meta_q;

   // first stage feeds only the second stage
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         meta_q   <= 1'b0;
         sync_out <= 1'b0;
      end else begin
         meta_q   <= async_in;
         sync_out <= meta_q;
      end
   end
endmodule

// ==== logic/lscs_top.sv ====
// lscs_top: low-speed clock source switch with its two control registers.
// assumes a one-cycle-strobe register port, read data one cycle later, and
// a boot-repeat level from outside the clock domain.
`timescale 1ns/10ps
module lscs_top
   import lscs_pkg::*;
#(
   parameter int TICK_DIV = LSCS_TICK_DIV
) (
   input  wire logic                   sys_clk_in,
   input  wire logic                   rst_n_in,
   input  wire logic [LSCS_ADDR_W-1:0] addr_in,
   input  wire logic [LSCS_DATA_W-1:0] wdata_in,
   input  wire logic                   wr_in,
   input  wire logic                   rd_in,
   input  wire logic                   sleep_clear_in,
   input  wire logic                   boot_repeat_in,
   input  wire logic                   ext_clk_en_in,
   output logic [LSCS_DATA_W-1:0]      rdata_out,
   output logic                        xtal_src_out,
   output logic                        ilo_en_out,
   output logic                        src_pending_out,
   output logic                        sleep_timeout_out,
   output logic                        ram_init_max_out,
   output logic [15:0]                 main_osc_khz_out,
   output logic                        system_clock_net_slow_out
);
   import lscs_pkg::*;

   logic [7:0]  osc_ctrl0_q;
   logic        xtal_exists_q;
   logic        xtal_written_q;
   logic        slow_main_q;
   logic        ram_init_dis_q;
   logic        boot_repeat_q;
   logic        boot_repeat_sync;
   lscs_src_t   src_q;
   logic [$clog2(TICK_DIV+1)-1:0] div_q;
   logic        tick;
   logic        timeout;
   logic        wr_osc;
   logic        wr_sys;
   logic        rd_sys;
   logic        sel_bit;
   logic [7:0]  rd_mux;

   // system register ignores the bank bit; oscillator register is banked
   function automatic logic is_sys(input logic [LSCS_ADDR_W-1:0] a);
      return a[7:0] == LSCS_SYS_SC1_OFS;
   endfunction

   assign wr_osc  = wr_in && (addr_in == LSCS_OSC_CTRL0_ADDR);
   assign wr_sys  = wr_in && is_sys(addr_in);
   assign rd_sys  = rd_in && is_sys(addr_in);
   assign sel_bit = osc_ctrl0_q[LSCS_XTAL_SEL_BIT];

   // boot-repeat level arrives from the boot sequencer's domain
   lscs_sync u_boot_sync (
      .sys_clk_in (sys_clk_in),
      .rst_n_in   (rst_n_in),
      .async_in   (boot_repeat_in),
      .sync_out   (boot_repeat_sync)
   );

   // 32 kHz tick enable from the system clock
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         div_q <= '0;
      end else if (div_q == $bits(div_q)'(TICK_DIV - 1)) begin
         div_q <= '0;
      end else begin
         div_q <= div_q + 1'b1;
      end
   end
   assign tick = (div_q == $bits(div_q)'(TICK_DIV - 1));

   lscs_sleep_timer u_sleep (
      .sys_clk_in  (sys_clk_in),
      .rst_n_in    (rst_n_in),
      .tick_in     (tick),
      .clear_in    (sleep_clear_in),
      .interval_in (osc_ctrl0_q[LSCS_SLEEP_HI:LSCS_SLEEP_LO]),
      .timeout_out (timeout)
   );

   // oscillator control 0; all bits stored, reserved bits are software's care
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         osc_ctrl0_q <= LSCS_OSC_CTRL0_RST;
      end else if (wr_osc) begin
         osc_ctrl0_q <= wdata_in & LSCS_OSC_CTRL0_WMASK;
      end
   end

   // crystal-exists flag and its written status lock on the first write
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         xtal_exists_q  <= LSCS_SYS_SC1_RST[LSCS_XTAL_EX_BIT];
         xtal_written_q <= LSCS_SYS_SC1_RST[LSCS_XTAL_WR_BIT];
      end else if (wr_sys && !xtal_written_q) begin
         xtal_exists_q  <= wdata_in[LSCS_XTAL_EX_BIT];
         xtal_written_q <= 1'b1;
      end
   end

   // free control bits of the system register
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         slow_main_q    <= LSCS_SYS_SC1_RST[LSCS_SLOW_MAIN_BIT];
         ram_init_dis_q <= LSCS_SYS_SC1_RST[LSCS_RAM_INIT_BIT];
      end else if (wr_sys) begin
         slow_main_q    <= wdata_in[LSCS_SLOW_MAIN_BIT];
         ram_init_dis_q <= wdata_in[LSCS_RAM_INIT_BIT];
      end
   end

   // boot-repeat status is a plain sampled level, read-only
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         boot_repeat_q <= 1'b0;
      end else begin
         boot_repeat_q <= boot_repeat_sync;
      end
   end

   // source state: pending waits for the timeout, clearing select is instant.
   // the exists flag is checked in the internal and pending states, so a never-written flag cannot arm.
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         src_q <= LSCS_SRC_ILO;
      end else begin
         unique case (src_q)
            LSCS_SRC_ILO: begin
               if (sel_bit && xtal_exists_q) begin
                  src_q <= LSCS_SRC_PEND;
               end
            end
            LSCS_SRC_PEND: begin
               if (!sel_bit || !xtal_exists_q) begin
                  src_q <= LSCS_SRC_ILO;
               end else if (timeout) begin
                  src_q <= LSCS_SRC_XTAL;
               end
            end
            LSCS_SRC_XTAL: begin
               if (!sel_bit) begin
                  src_q <= LSCS_SRC_ILO;
               end
            end
            default: src_q <= LSCS_SRC_ILO;
         endcase
      end
   end

   // source outputs registered; the internal oscillator stays on until switch
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         xtal_src_out      <= 1'b0;
         ilo_en_out        <= 1'b1;
         src_pending_out   <= 1'b0;
         sleep_timeout_out <= 1'b0;
      end else begin
         xtal_src_out      <= (src_q == LSCS_SRC_XTAL);
         ilo_en_out        <= (src_q != LSCS_SRC_XTAL);
         src_pending_out   <= (src_q == LSCS_SRC_PEND);
         sleep_timeout_out <= timeout;
      end
   end

   // main oscillator rate and system clock slowdown
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         main_osc_khz_out <= LSCS_MAIN_KHZ_FAST;
         system_clock_net_slow_out  <= 1'b0;
         ram_init_max_out <= 1'b1;
      end else begin
         if (slow_main_q) begin
            main_osc_khz_out <= LSCS_MAIN_KHZ_SLOW;
         end else if (osc_ctrl0_q[LSCS_PLL_MODE_BIT] && src_q == LSCS_SRC_XTAL) begin
            main_osc_khz_out <= LSCS_MAIN_KHZ_PLL;
         end else begin
            main_osc_khz_out <= LSCS_MAIN_KHZ_FAST;
         end
         system_clock_net_slow_out  <= slow_main_q && !ext_clk_en_in;
         ram_init_max_out <= !ram_init_dis_q;
      end
   end

   // read mux
   always_comb begin
      rd_mux = 8'h00;
      if (is_sys(addr_in)) begin
         rd_mux[LSCS_BOOT_REP_BIT]  = boot_repeat_q;
         rd_mux[LSCS_SLOW_MAIN_BIT] = slow_main_q;
         rd_mux[LSCS_XTAL_WR_BIT]   = xtal_written_q;
         rd_mux[LSCS_XTAL_EX_BIT]   = xtal_exists_q;
         rd_mux[LSCS_RAM_INIT_BIT]  = ram_init_dis_q;
      end else if (addr_in == LSCS_OSC_CTRL0_ADDR) begin
         rd_mux = osc_ctrl0_q;
      end else if (addr_in == LSCS_SRC_STAT_ADDR) begin
         rd_mux[LSCS_STAT_XTAL_BIT] = (src_q == LSCS_SRC_XTAL);
         rd_mux[LSCS_STAT_PEND_BIT] = (src_q == LSCS_SRC_PEND);
         rd_mux[LSCS_STAT_ILO_BIT]  = (src_q != LSCS_SRC_XTAL);
      end
   end

   // read data stands only in the cycle after the strobe; unmapped reads 00
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rdata_out <= 8'h00;
      end else if (rd_in) begin
         rdata_out <= rd_mux;
      end else begin
         rdata_out <= 8'h00;
      end
   end

   sequence s_first_write;
      wr_sys && !xtal_written_q;
   endsequence

   a_flag_write_once: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      xtal_written_q |=> $stable(xtal_exists_q)) else $error("exists flag changed after lock");
   a_written_sets: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      s_first_write |=> xtal_written_q && xtal_exists_q == $past(wdata_in[LSCS_XTAL_EX_BIT]))
      else $error("written status not set on first write");
   a_lockout_holds: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      !xtal_exists_q |=> !xtal_src_out [*2]) else $error("crystal selected without flag");
   a_no_arm_unflagged: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      (src_q == LSCS_SRC_ILO && !xtal_exists_q) |=> src_q == LSCS_SRC_ILO)
      else $error("switch armed without flag");
   a_switch_on_timeout: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      (src_q == LSCS_SRC_PEND && sel_bit && xtal_exists_q && timeout) |=> ##1 xtal_src_out && !ilo_en_out)
      else $error("no switch at timeout");
   a_wait_for_timeout: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      (src_q == LSCS_SRC_PEND && !timeout) |=> src_q != LSCS_SRC_XTAL)
      else $error("switch before timeout");
   a_ilo_runs_pending: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      src_q != LSCS_SRC_XTAL |=> ilo_en_out) else $error("internal oscillator stopped early");
   a_back_at_once: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      (src_q == LSCS_SRC_XTAL && !sel_bit) |=> ##1 ilo_en_out && !xtal_src_out)
      else $error("return to internal delayed");
   a_sel_needed: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      $fell(sel_bit) |=> ##1 !xtal_src_out) else $error("crystal kept without select");
   a_slow_main: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      slow_main_q |=> main_osc_khz_out == LSCS_MAIN_KHZ_SLOW) else $error("slow rate missing");
   a_bank_free: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      (rd_in && is_sys(addr_in)) |=> rdata_out[LSCS_XTAL_WR_BIT] == $past(xtal_written_q))
      else $error("system register not visible in bank");

   // switch steps: armed, pending shown, timeout taken, crystal shown
   sequence s_select_armed;
      sel_bit && xtal_exists_q && src_q == LSCS_SRC_ILO;
   endsequence

   sequence s_pending_shown;
      src_q == LSCS_SRC_PEND ##1 src_pending_out;
   endsequence

   sequence s_timeout_taken;
      src_q == LSCS_SRC_PEND && sel_bit && xtal_exists_q && timeout;
   endsequence

   sequence s_crystal_shown;
      src_q == LSCS_SRC_XTAL ##1 xtal_src_out && !ilo_en_out;
   endsequence

   // source selection, gated by the select bit and the exists flag
   a_reset_source: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      $rose(rst_n_in) |-> !xtal_src_out && ilo_en_out && !src_pending_out)
      else $error("reset source not internal");
   a_arm_pending: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      s_select_armed |=> s_pending_shown)
      else $error("armed select not pending");
   a_timeout_switch: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      s_timeout_taken |=> s_crystal_shown)
      else $error("timeout did not switch");
   a_pending_abort: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      (src_q == LSCS_SRC_PEND && !sel_bit) |=> src_q == LSCS_SRC_ILO)
      else $error("pending switch not aborted");
   a_sel_required: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      !sel_bit |=> ##1 !xtal_src_out)
      else $error("crystal without select");
   a_unflagged_ilo: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      !xtal_exists_q |-> src_q == LSCS_SRC_ILO)
      else $error("source left internal without flag");
   a_timeout_pulse: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      sleep_timeout_out |=> !sleep_timeout_out)
      else $error("timeout pulse too long");

   // rate, clock and ram-init outputs follow their control bits
   a_pll_rate: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      (osc_ctrl0_q[LSCS_PLL_MODE_BIT] && src_q == LSCS_SRC_XTAL && !slow_main_q) |=>
      main_osc_khz_out == LSCS_MAIN_KHZ_PLL) else $error("pll rate missing");
   a_no_pll_internal: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      (src_q != LSCS_SRC_XTAL && !slow_main_q) |=> main_osc_khz_out == LSCS_MAIN_KHZ_FAST)
      else $error("pll rate without crystal");
   a_system_clock_net_slow: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      (slow_main_q && !ext_clk_en_in) |=> system_clock_net_slow_out)
      else $error("system clock not slowed");
   a_system_clock_net_ext: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      (!slow_main_q || ext_clk_en_in) |=> !system_clock_net_slow_out)
      else $error("system clock slowed wrongly");
   a_ram_init_max: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      !ram_init_dis_q |=> ram_init_max_out)
      else $error("full ram clear not selected");
   a_ram_init_min: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      ram_init_dis_q |=> !ram_init_max_out)
      else $error("minimum ram clear not selected");

   // read-back of the status bits and oscillator control 0; rd_sys ignores the bank bit
   a_written_reads: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      (rd_sys && !xtal_written_q) |=> !rdata_out[LSCS_XTAL_WR_BIT])
      else $error("written status read early");
   a_written_sticky: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      xtal_written_q |=> xtal_written_q)
      else $error("written status dropped");
   a_exists_reads: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      rd_sys |=> rdata_out[LSCS_XTAL_EX_BIT] == $past(xtal_exists_q))
      else $error("exists flag misread");
   a_boot_reads: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      rd_sys |=> rdata_out[LSCS_BOOT_REP_BIT] == $past(boot_repeat_q))
      else $error("boot-repeat status misread");
   a_osc_reads: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      (rd_in && addr_in == LSCS_OSC_CTRL0_ADDR) |=> rdata_out == $past(osc_ctrl0_q))
      else $error("oscillator control misread");
endmodule

// ==== pkg/lscs_pkg.sv ====
// lscs_pkg: register map, field positions, reset values and timing constants
// of the low-speed clock source switch.
// assumes a byte-wide register port with 9-bit addresses (bank bit + offset).
package lscs_pkg;
   localparam int          LSCS_ADDR_W          = 9;
   localparam int          LSCS_DATA_W          = 8;
   // oscillator control 0 sits in bank 1; system status/control 1 in every bank
   localparam logic [8:0]  LSCS_OSC_CTRL0_ADDR  = 9'h1E0;
   localparam logic [7:0]  LSCS_SYS_SC1_OFS     = 8'hFE;
   localparam logic [8:0]  LSCS_SRC_STAT_ADDR   = 9'h1F0;
   localparam logic [7:0]  LSCS_OSC_CTRL0_RST   = 8'h00;
   localparam logic [7:0]  LSCS_SYS_SC1_RST     = 8'h00;
   localparam logic [7:0]  LSCS_OSC_CTRL0_WMASK = 8'hFF;
   // oscillator control 0 fields
   localparam int          LSCS_XTAL_SEL_BIT    = 7;
   localparam int          LSCS_PLL_MODE_BIT    = 6;
   localparam int          LSCS_SLEEP_HI        = 4;
   localparam int          LSCS_SLEEP_LO        = 3;
   // system status/control 1 fields
   localparam int          LSCS_BOOT_REP_BIT    = 7;
   localparam int          LSCS_SLOW_MAIN_BIT   = 4;
   localparam int          LSCS_XTAL_WR_BIT     = 3;
   localparam int          LSCS_XTAL_EX_BIT     = 2;
   localparam int          LSCS_RAM_INIT_BIT    = 0;
   // source status fields
   localparam int          LSCS_STAT_XTAL_BIT   = 0;
   localparam int          LSCS_STAT_PEND_BIT   = 1;
   localparam int          LSCS_STAT_ILO_BIT    = 2;
   // sleep interval codes and tick counts
   localparam logic [1:0]  LSCS_SLEEP_1S        = 2'h3;
   localparam int          LSCS_SLEEP_CNT_W     = 15;
   localparam logic [14:0] LSCS_SLEEP_TICKS0    = 15'h003F;
   localparam logic [14:0] LSCS_SLEEP_TICKS1    = 15'h01FF;
   localparam logic [14:0] LSCS_SLEEP_TICKS2    = 15'h0FFF;
   localparam logic [14:0] LSCS_SLEEP_TICKS3    = 15'h7FFF;
   // main oscillator rates in kHz, fed to the clock generator
   localparam logic [15:0] LSCS_MAIN_KHZ_FAST   = 16'h5DC0;
   localparam logic [15:0] LSCS_MAIN_KHZ_SLOW   = 16'h1770;
   localparam logic [15:0] LSCS_MAIN_KHZ_PLL    = 16'h5DB2;
   // clock rate and the 32 kHz tick derivation
   localparam int          LSCS_CLK_HZ          = 100_000_000;
   localparam int          LSCS_TICK_HZ         = 32_768;
   localparam int          LSCS_TICK_DIV        = LSCS_CLK_HZ / LSCS_TICK_HZ;
   typedef enum logic [1:0] {LSCS_SRC_ILO, LSCS_SRC_PEND, LSCS_SRC_XTAL} lscs_src_t;
endpackage
